// File: pc_bank_pkg.sv
// constants and types for the program counter, bank select and table write control
// Function
// - sixteen-bit counter increments in first phase
// - low byte mapped; high byte only via latch
// - taken skip executes forced no-operation cycle
// - long call: latch to high, field to low
// - low-byte read copies high byte into latch
// - low-byte write loads high byte from latch
// - read-modify-write jumps within page, latch kept
// - return loads counter from top stack entry
// - call/jump load thirteen bits, refresh latch
// - latch kept on long call, returns, vector
// - bank select: low peripheral, high ram nibble
// - only special addresses 10h-17h peripheral-banked
// - missing bank reads zero, writes discarded
// - two byte transfers, four table instructions
// - external table access only in extended modes
// - internal table write starts halting long write
// - only reset or enabled flagged interrupt ends
// - no programming voltage: plain two-cycle write
// - core source ending write gets flag cleared
// - pending interrupt aborts write, clears core flag
// - peripheral source flag stays set
// - vector after end only if not disabled
package pc_bank_pkg;
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_PCL_READ  = 4'h1,
        OP_PCL_WRITE = 4'h2,
        OP_PCL_RMW   = 4'h3,
        OP_GOTO      = 4'h4,
        OP_CALL      = 4'h5,
        OP_LONG_CALL_INSN     = 4'h6,
        OP_RETURN    = 4'h7,
        OP_SKIP      = 4'h8,
        OP_LOAD_PERIPHERAL_BANK_INSN     = 4'h9,
        OP_LOAD_RAM_BANK_INSN     = 4'hA,
        OP_TBL_WRITE = 4'hB,
        OP_TLAT_WR   = 4'hC,
        OP_TBL_READ  = 4'hD,
        OP_TLAT_RD   = 4'hE,
        OP_VECTOR    = 4'hF
    } op_t;
    typedef enum logic [1:0] {Q1 = 2'h0, Q2 = 2'h1, Q3 = 2'h2, Q4 = 2'h3} phase_t;
    typedef enum logic [1:0] {TW_IDLE = 2'h0, TW_SECOND = 2'h1, TW_LONG = 2'h2} tw_t;
    typedef struct packed {
        op_t         op;
        logic [12:0] field;
        logic [7:0]  data;
        logic [15:0] stackTop;
    } insn_t;
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_t;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [15:0] INT_VECTOR     = 16'h0020;
    localparam logic [7:0]  SFR_BANK_LO    = 8'h10;
    localparam logic [7:0]  SFR_BANK_HI    = 8'h17;
    localparam logic [7:0]  GPR_BANK_LO    = 8'h20;
    localparam logic [15:0] PERIPH_IMPL    = 16'h00FF;
    localparam logic [15:0] RAM_IMPL       = 16'h000F;
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_PC         = 4'h8;
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          STAT_LONG_BIT  = 24;
endpackage

// File: pc_bank_table_write_ctrl.sv
// program counter, bank select and table write sequencer of the core
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pc_bank_table_write_ctrl (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // avalon-mm slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // instruction decoder
    input  wire logic                 insnValid,
    input  wire pc_bank_pkg::insn_t   insn,
    output logic                      insnReady,
    output logic      [15:0]          pc,
    output logic      [7:0]           pcHighLatch,
    output logic      [7:0]           bankSelect,
    output logic      [7:0]           pclRdData,
    output logic                      forcedNop,
    // data memory access
    input  wire pc_bank_pkg::mem_req_t memReq,
    input  wire logic [7:0]           memRdIn,
    output logic      [7:0]           memRdOut,
    output logic                      memWrEn,
    output logic      [3:0]           memBank,
    // interrupt logic: 0 pin, 1 timer zero, 2 timer clock, 3 peripheral
    input  wire logic [3:0]           intFlag,
    input  wire logic [3:0]           intEnable,
    input  wire logic                 globalIntDisable,
    output logic      [2:0]           clearFlag,
    output logic                      vectorTaken,
    // program memory and pins
    input  wire logic                 programVoltagePin,
    output logic                      tableStrobe,
    output logic      [3:0]           tableOp,
    output logic                      progWrite,
    output logic                      progExternal,
    output logic                      longWrite
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] highestCore(input logic [3:0] pend);
        highestCore = pend[0] ? 3'h1 : pend[1] ? 3'h2 : pend[2] ? 3'h4 : 3'h0;
    endfunction
    function automatic logic bankMissing(input logic [7:0] a, input logic [7:0] b);
        if (a >= pc_bank_pkg::SFR_BANK_LO && a <= pc_bank_pkg::SFR_BANK_HI)
            bankMissing = !pc_bank_pkg::PERIPH_IMPL[b[3:0]];
        else if (a >= pc_bank_pkg::GPR_BANK_LO)
            bankMissing = !pc_bank_pkg::RAM_IMPL[b[7:4]];
        else
            bankMissing = 1'b0;
    endfunction

    logic [15:0]         pc_q, pc_d;
    logic [7:0]          latch_q, latch_d;
    logic [7:0]          bsr_q, bsr_d;
    logic [7:0]          pclRd_q;
    logic                pcLoaded_q, pcLoaded_d;
    logic                nop_q;
    pc_bank_pkg::phase_t phase_q;
    pc_bank_pkg::tw_t    tw_q, tw_d;
    logic                extMode_q;
    logic                vpp1_q, vpp2_q, vpp3_q, vppOk_q;
    logic [2:0]          clr_q, clr_d;
    logic                vec_q;
    logic                tStrobe_q, pWrite_q, pWrite_d, pExt_q;
    logic [3:0]          tOp_q;
    logic [7:0]          memRd_q;
    logic                memWr_q;
    logic [3:0]          memBank_q;
    logic [31:0]         rdData_q;
    logic                wait_q;
    // ready and long-write levels are flopped so the decoder never sees a decode glitch
    logic                ready_q, longWr_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire        busy       = (tw_q != pc_bank_pkg::TW_IDLE);
    wire        exec       = insnValid && phase_q == pc_bank_pkg::Q4 && !busy;
    wire [3:0]  pending    = intFlag & intEnable;
    wire        anyPending = |pending;
    wire [2:0]  coreClr    = highestCore(pending);
    wire        isTblWr    = exec && insn.op == pc_bank_pkg::OP_TBL_WRITE;
    wire        longEnd    = tw_q == pc_bank_pkg::TW_LONG && anyPending;
    wire        incr       = phase_q == pc_bank_pkg::Q1 && !pcLoaded_q && !busy;
    wire        missing    = bankMissing(memReq.addr, bsr_q);
    wire        busReq     = avs_read || avs_write;
    wire        busDone    = busReq && !wait_q;
    wire [31:0] busRead    = avs_address == pc_bank_pkg::REG_CTRL   ? {31'h0, extMode_q} :
                             avs_address == pc_bank_pkg::REG_STATUS ? {7'h0, busy, bsr_q, 8'h00, latch_q} :
                             avs_address == pc_bank_pkg::REG_PC     ? {16'h0000, pc_q} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // next-state of counter, latch, bank select and sequencer
    always_comb begin
        pc_d       = pc_q;
        latch_d    = latch_q;
        bsr_d      = bsr_q;
        tw_d       = tw_q;
        clr_d      = 3'h0;
        pWrite_d   = 1'b0;
        pcLoaded_d = pcLoaded_q;
        if (incr) begin
            pc_d       = pc_q + 16'h0001;
        end
        if (phase_q == pc_bank_pkg::Q1) begin
            pcLoaded_d = 1'b0;
        end
        if (exec) begin
            case (insn.op)
                pc_bank_pkg::OP_PCL_READ: begin
                    latch_d = pc_q[15:8];
                end
                pc_bank_pkg::OP_PCL_WRITE, pc_bank_pkg::OP_PCL_RMW: begin
                    pc_d       = {latch_q, insn.data};
                    pcLoaded_d = 1'b1;
                end
                pc_bank_pkg::OP_GOTO, pc_bank_pkg::OP_CALL: begin
                    pc_d       = {pc_q[15:13], insn.field};
                    latch_d    = {pc_q[15:13], insn.field[12:8]};
                    pcLoaded_d = 1'b1;
                end
                pc_bank_pkg::OP_LONG_CALL_INSN: begin
                    pc_d       = {latch_q, insn.field[7:0]};
                    pcLoaded_d = 1'b1;
                end
                pc_bank_pkg::OP_RETURN: begin
                    pc_d       = insn.stackTop;
                    pcLoaded_d = 1'b1;
                end
                pc_bank_pkg::OP_VECTOR: begin
                    pc_d       = pc_bank_pkg::INT_VECTOR;
                    pcLoaded_d = 1'b1;
                end
                pc_bank_pkg::OP_LOAD_PERIPHERAL_BANK_INSN: begin
                    bsr_d[3:0] = insn.data[3:0];
                end
                pc_bank_pkg::OP_LOAD_RAM_BANK_INSN: begin
                    bsr_d[7:4] = insn.data[7:4];
                end
                pc_bank_pkg::OP_TBL_WRITE: begin
                    if (anyPending) begin
                        clr_d = coreClr;
                    end else if (extMode_q || !vppOk_q) begin
                        tw_d = pc_bank_pkg::TW_SECOND;
                    end else begin
                        tw_d = pc_bank_pkg::TW_LONG;
                    end
                end
                default: begin
                end
            endcase
        end
        case (tw_q)
            pc_bank_pkg::TW_SECOND: begin
                if (phase_q == pc_bank_pkg::Q4) begin
                    tw_d     = pc_bank_pkg::TW_IDLE;
                    // without programming voltage the internal array is left alone
                    pWrite_d = extMode_q;
                end
            end
            pc_bank_pkg::TW_LONG: begin
                if (longEnd) begin
                    tw_d  = pc_bank_pkg::TW_IDLE;
                    clr_d = coreClr;
                    if (!globalIntDisable) begin
                        pc_d       = pc_bank_pkg::INT_VECTOR;
                        pcLoaded_d = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // core state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_q       <= pc_bank_pkg::PC_RESET;
            latch_q    <= 8'h00;
            bsr_q      <= 8'h00;
            tw_q       <= pc_bank_pkg::TW_IDLE;
            pcLoaded_q <= 1'b0;
            phase_q    <= pc_bank_pkg::Q1;
            clr_q      <= 3'h0;
            vec_q      <= 1'b0;
            pWrite_q   <= 1'b0;
            ready_q    <= 1'b1;
            longWr_q   <= 1'b0;
        end else begin
            pc_q       <= pc_d;
            latch_q    <= latch_d;
            bsr_q      <= bsr_d;
            tw_q       <= tw_d;
            pcLoaded_q <= pcLoaded_d;
            phase_q    <= pc_bank_pkg::phase_t'(phase_q + 2'h1);
            clr_q      <= clr_d;
            vec_q      <= longEnd && !globalIntDisable;
            pWrite_q   <= pWrite_d || (isTblWr && tw_d == pc_bank_pkg::TW_LONG);
            ready_q    <= tw_d == pc_bank_pkg::TW_IDLE;
            longWr_q   <= tw_d == pc_bank_pkg::TW_LONG;
        end
    end

    // strobes to the outside world
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pclRd_q   <= 8'h00;
            nop_q     <= 1'b0;
            tStrobe_q <= 1'b0;
            tOp_q     <= 4'h0;
            pExt_q    <= 1'b0;
        end else begin
            pclRd_q   <= (exec && insn.op == pc_bank_pkg::OP_PCL_READ) ? pc_q[7:0] : pclRd_q;
            nop_q     <= exec && (insn.op == pc_bank_pkg::OP_SKIP || (isTblWr && anyPending));
            tStrobe_q <= exec && insn.op inside {pc_bank_pkg::OP_TBL_WRITE, pc_bank_pkg::OP_TLAT_WR,
                                                 pc_bank_pkg::OP_TBL_READ, pc_bank_pkg::OP_TLAT_RD};
            tOp_q     <= exec ? insn.op : tOp_q;
            pExt_q    <= extMode_q;
        end
    end

    // banked data memory path; arithmetic flags stay with the alu
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memRd_q   <= 8'h00;
            memWr_q   <= 1'b0;
            memBank_q <= 4'h0;
        end else begin
            memRd_q   <= missing ? 8'h00 : memRdIn;
            memWr_q   <= memReq.valid && memReq.write && !missing;
            memBank_q <= (memReq.addr <= pc_bank_pkg::SFR_BANK_HI) ? bsr_q[3:0] : bsr_q[7:4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // programming voltage pin: three stages, change accepted when last two agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vpp1_q  <= 1'b0;
            vpp2_q  <= 1'b0;
            vpp3_q  <= 1'b0;
            vppOk_q <= 1'b0;
        end else begin
            vpp1_q  <= programVoltagePin;
            vpp2_q  <= vpp1_q;
            vpp3_q  <= vpp2_q;
            vppOk_q <= (vpp2_q == vpp3_q) ? vpp3_q : vppOk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then answer; write lands on the answering edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q    <= 1'b1;
            rdData_q  <= 32'h0000_0000;
            extMode_q <= 1'b0;
        end else begin
            wait_q    <= !(busReq && wait_q);
            rdData_q  <= (avs_read && wait_q) ? busRead : rdData_q;
            if (busDone && avs_write && avs_address == pc_bank_pkg::REG_CTRL && avs_byteenable[0]) begin
                extMode_q <= avs_writedata[pc_bank_pkg::CTRL_EXT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign avs_readdata    = rdData_q;
    assign avs_waitrequest = wait_q;
    assign insnReady       = ready_q;
    assign pc              = pc_q;
    assign pcHighLatch     = latch_q;
    assign bankSelect      = bsr_q;
    assign pclRdData       = pclRd_q;
    assign forcedNop       = nop_q;
    assign memRdOut        = memRd_q;
    assign memWrEn         = memWr_q;
    assign memBank         = memBank_q;
    assign clearFlag       = clr_q;
    assign vectorTaken     = vec_q;
    assign tableStrobe     = tStrobe_q;
    assign tableOp         = tOp_q;
    assign progWrite       = pWrite_q;
    assign progExternal    = pExt_q;
    assign longWrite       = longWr_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    pc_incr_a: assert property (incr && !exec |=> pc_q == $past(pc_q) + 16'h0001)
        else $error("counter did not increment");
    pcl_read_a: assert property (exec && insn.op == pc_bank_pkg::OP_PCL_READ
        |=> pclRd_q == $past(pc_q[7:0]) && latch_q == $past(pc_q[15:8]))
        else $error("low byte read wrong");
    pcl_write_a: assert property (exec && insn.op == pc_bank_pkg::OP_PCL_WRITE
        |=> pc_q == {$past(latch_q), $past(insn.data)} ##1 pc_q == $past(pc_q))
        else $error("low byte write wrong");
    rmw_page_a: assert property (exec && insn.op == pc_bank_pkg::OP_PCL_RMW
        |=> pc_q[15:8] == $past(latch_q) && $stable(latch_q))
        else $error("computed jump left page");
    long_call_insn_load_a: assert property (exec && insn.op == pc_bank_pkg::OP_LONG_CALL_INSN
        |=> pc_q == {latch_q, $past(insn.field[7:0])} && $stable(latch_q))
        else $error("long call load wrong");
    goto_latch_a: assert property (exec && insn.op == pc_bank_pkg::OP_GOTO
        |=> latch_q == {$past(pc_q[15:13]), $past(insn.field[12:8])})
        else $error("jump latch update wrong");
    return_load_a: assert property (exec && insn.op == pc_bank_pkg::OP_RETURN
        |=> pc_q == $past(insn.stackTop) && $stable(latch_q))
        else $error("return load wrong");
    skip_nop_a: assert property (exec && insn.op == pc_bank_pkg::OP_SKIP |=> nop_q)
        else $error("skip lost its forced nop");
    long_halt_a: assert property (longWrite && !anyPending |=> $stable(pc_q) && !insnReady)
        else $error("counter moved during long write");
    long_end_a: assert property (longWrite && anyPending |=> !longWrite)
        else $error("long write not ended");
    core_clear_a: assert property (longWrite && pending[0] |=> clr_q == 3'h1)
        else $error("pin flag not cleared");
    abort_nop_a: assert property (isTblWr && anyPending |=> nop_q && !longWrite && !pWrite_q)
        else $error("pending interrupt did not abort");
    vector_end_a: assert property (longWrite && anyPending && !globalIntDisable
        |=> vec_q && pc_q == pc_bank_pkg::INT_VECTOR)
        else $error("no vector after long write");
    missing_read_a: assert property (missing |=> memRd_q == 8'h00 && !memWr_q)
        else $error("missing bank not silent");
    plain_write_a: assert property (isTblWr && !anyPending && !vppOk_q && !extMode_q
        |=> busy [*4] ##1 !busy && !longWrite)
        else $error("unpowered write not two cycles");

    long_end_c: cover property (longWrite ##[1:50] !longWrite);
    abort_c: cover property (isTblWr && anyPending);
    pcl_write_c: cover property (exec && insn.op == pc_bank_pkg::OP_PCL_WRITE);
    bus_c: cover property (busDone && avs_write);
endmodule
`default_nettype wire

// File: far_side_model.sv
// data memory and interrupt flag model facing the core control block
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // data memory
    input  wire pc_bank_pkg::mem_req_t memReq,
    output logic      [7:0]            memRdIn,
    // interrupt flags
    input  wire logic [3:0]            setFlag,
    input  wire logic                  wipe,
    input  wire logic [2:0]            clearFlag,
    output logic      [3:0]            intFlag
);
    logic [7:0] lastRd_q;
    // unselected memory shows the inverse of the last value, so stale data cannot pass
    assign memRdIn = memReq.valid ? ({memReq.addr[3:0], ~memReq.addr[7:4]} ^ 8'h3C) : ~lastRd_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lastRd_q <= 8'h00;
            intFlag  <= 4'h0;
        end else begin
            lastRd_q <= memRdIn;
            intFlag  <= wipe ? 4'h0 : (intFlag | setFlag) & ~{1'b0, clearFlag};
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the program counter, bank select and table write block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, reset_n, avs_read, avs_write, insnValid, gid, vpp, wipe;
    logic [3:0] avs_address, intEnable, setFlag, intFlag;
    logic [31:0] avs_writedata, avs_readdata, rs, r, q, ec;
    logic avs_waitrequest, insnReady, forcedNop, memWrEn, vectorTaken, tableStrobe, progWrite, progExternal, longWrite;
    logic [15:0] pc, s, p;
    logic [7:0] pcHighLatch, bankSelect, pclRdData, memRdOut, memRdIn, eLat, bs, a;
    logic [2:0] clearFlag;
    logic [3:0] memBank, tableOp;
    logic [12:0] f;
    pc_bank_pkg::insn_t insn;
    pc_bank_pkg::mem_req_t memReq;
    int mismatches, n_checks, k, np, nl;
    pc_bank_table_write_ctrl dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .insnValid(insnValid), .insn(insn), .insnReady(insnReady), .pc(pc),
        .pcHighLatch(pcHighLatch), .bankSelect(bankSelect), .pclRdData(pclRdData), .forcedNop(forcedNop),
        .memReq(memReq), .memRdIn(memRdIn), .memRdOut(memRdOut), .memWrEn(memWrEn), .memBank(memBank),
        .intFlag(intFlag), .intEnable(intEnable), .globalIntDisable(gid), .clearFlag(clearFlag),
        .vectorTaken(vectorTaken), .programVoltagePin(vpp), .tableStrobe(tableStrobe), .tableOp(tableOp),
        .progWrite(progWrite), .progExternal(progExternal), .longWrite(longWrite));
    far_side_model peer (.clk(clk), .reset_n(reset_n), .memReq(memReq), .memRdIn(memRdIn), .setFlag(setFlag),
        .wipe(wipe), .clearFlag(clearFlag), .intFlag(intFlag));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic impl(logic [7:0] ad, logic [7:0] sel);
        if (ad >= pc_bank_pkg::SFR_BANK_LO && ad <= pc_bank_pkg::SFR_BANK_HI) return pc_bank_pkg::PERIPH_IMPL[sel[3:0]];
        if (ad >= pc_bank_pkg::GPR_BANK_LO) return pc_bank_pkg::RAM_IMPL[sel[7:4]];
        return 1'b1;
    endfunction
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // instructions are only taken on the fourth-phase edge, so present them one edge before
    task automatic ex(input pc_bank_pkg::op_t o, input logic [12:0] fl, input logic [7:0] d, input logic [15:0] st);
        do @(posedge clk); while (ec[1:0] != 2'h2);
        insnValid <= 1'b1;
        insn <= {o, fl, d, st};
        @(posedge clk);
        insnValid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic watch();
        np = 0;
        nl = 0;
        repeat (8) begin @(negedge clk); if (progWrite !== 1'b0) np++; if (longWrite !== 1'b0) nl++; end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) ec <= 32'h0;
        else ec <= ec + 32'h1;
    end
    // whole run needs a few hundred cycles; a hang is cut well after that
    always @(posedge clk) if (ec == 32'd20000) begin mismatches++; final_report(); end
    initial begin
        {avs_read, avs_write, insnValid, gid, vpp, wipe, avs_address, intEnable, setFlag} = '0;
        avs_writedata = '0; insn = '0; memReq = '0; rs = 32'hC359; eLat = 8'h00; reset_n = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, pc_bank_pkg::REG_CTRL, 32'h0, q); ck(q, 32'h0);
        bus(1'b1, pc_bank_pkg::REG_CTRL, 32'h1, q); bus(1'b0, pc_bank_pkg::REG_CTRL, 32'h0, q); ck(q, 32'h1);
        bus(1'b1, 4'hC, 32'hFF, q); bus(1'b0, 4'hC, 32'h0, q); ck(q, 32'h0);
        ck(progExternal, 1'b1);
        bus(1'b1, pc_bank_pkg::REG_CTRL, 32'h0, q);
        $display("register test done");
        for (int i = 0; i < 6; i++) begin
            r = xs(); s = r[15:0]; f = r[28:16]; p = s + 16'h1;
            ex(pc_bank_pkg::OP_RETURN, 13'h0, 8'h00, s); ck(pc, s);
            ck(pcHighLatch, eLat);
            ex(pc_bank_pkg::OP_PCL_READ, 13'h0, 8'h00, 16'h0); ck(pclRdData, s[7:0]);
            ck(pcHighLatch, s[15:8]);
            ex(r[31] ? pc_bank_pkg::OP_CALL : pc_bank_pkg::OP_GOTO, f, 8'h00, 16'h0); ck(pc, {p[15:13], f});
            eLat = {p[15:13], f[12:8]}; ck(pcHighLatch, eLat);
            ex(pc_bank_pkg::OP_PCL_WRITE, 13'h0, r[23:16], 16'h0); ck(pc, {eLat, r[23:16]});
            ex(pc_bank_pkg::OP_PCL_RMW, 13'h0, r[7:0], 16'h0); ck(pc, {eLat, r[7:0]});
            ck(pcHighLatch, eLat);
        end
        ex(pc_bank_pkg::OP_LONG_CALL_INSN, 13'h55, 8'h00, 16'h0); ck(pc, {eLat, 8'h55});
        ck(pcHighLatch, eLat);
        repeat (4) @(negedge clk); ck(pc, {eLat, 8'h55});
        repeat (4) @(negedge clk); ck(pc, {eLat, 8'h56});
        ex(pc_bank_pkg::OP_SKIP, 13'h0, 8'h00, 16'h0); ck(forcedNop, 1'b1);
        @(negedge clk); ck(forcedNop, 1'b0);
        ex(pc_bank_pkg::OP_VECTOR, 13'h0, 8'h00, 16'h0); ck(pc, pc_bank_pkg::INT_VECTOR);
        ck(pcHighLatch, eLat);
        $display("counter test done");
        for (int b = 0; b < 2; b++) begin
            bs = b ? 8'h47 : 8'h29;
            ex(pc_bank_pkg::OP_LOAD_PERIPHERAL_BANK_INSN, 13'h0, {bs[3:0], bs[3:0]}, 16'h0);
            ex(pc_bank_pkg::OP_LOAD_RAM_BANK_INSN, 13'h0, {bs[7:4], bs[7:4]}, 16'h0); ck(bankSelect, bs);
            for (int i = 0; i < 6; i++) begin
                r = xs();
                a = (i < 2) ? 8'h10 : (i == 2) ? 8'h17 : (i == 3) ? 8'h0F : 8'h25;
                @(posedge clk) memReq <= {1'b1, i[0], a, r[7:0]};
                @(posedge clk) memReq <= '0;
                @(negedge clk);
                if (!i[0]) ck(memRdOut, impl(a, bs) ? ({a[3:0], ~a[7:4]} ^ 8'h3C) : 8'h00);
                else ck(memWrEn, impl(a, bs));
                if (a != 8'h0F) ck(memBank, (a < 8'h20) ? bs[3:0] : bs[7:4]);
            end
        end
        bus(1'b0, pc_bank_pkg::REG_STATUS, 32'h0, q); ck(q, {8'h00, bs, 8'h00, eLat});
        $display("bank test done");
        ex(pc_bank_pkg::OP_TLAT_WR, 13'h0, 8'h00, 16'h0); ck(tableOp, pc_bank_pkg::OP_TLAT_WR);
        ex(pc_bank_pkg::OP_TBL_READ, 13'h0, 8'h00, 16'h0); ck(tableStrobe, 1'b1);
        ex(pc_bank_pkg::OP_TLAT_RD, 13'h0, 8'h00, 16'h0); ck(tableOp, pc_bank_pkg::OP_TLAT_RD);
        intEnable <= 4'h6; setFlag <= 4'h6;
        @(posedge clk) setFlag <= 4'h0;
        ex(pc_bank_pkg::OP_TBL_WRITE, 13'h0, 8'h00, 16'h0); ck(forcedNop, 1'b1);
        ck(clearFlag, 3'h2);
        watch(); ck(np, 0);
        wipe <= 1'b1; intEnable <= 4'h0;
        @(posedge clk) wipe <= 1'b0;
        ex(pc_bank_pkg::OP_TBL_WRITE, 13'h0, 8'h00, 16'h0); watch(); ck(np + nl, 0);
        ck(insnReady, 1'b1);
        bus(1'b1, pc_bank_pkg::REG_CTRL, 32'h1, q);
        ex(pc_bank_pkg::OP_TBL_WRITE, 13'h0, 8'h00, 16'h0); watch(); ck(np, 1);
        bus(1'b1, pc_bank_pkg::REG_CTRL, 32'h0, q);
        vpp <= 1'b1;
        $display("table test done");
        for (int j = 0; j < 2; j++) begin
            intEnable <= j ? 4'h8 : 4'h1; gid <= j[0];
            ex(pc_bank_pkg::OP_GOTO, 13'h0100, 8'h00, 16'h0);
            ex(pc_bank_pkg::OP_TBL_WRITE, 13'h0, 8'h00, 16'h0); ck(longWrite, 1'b1);
            @(posedge clk) setFlag <= 4'h4;
            @(posedge clk) setFlag <= 4'h0;
            repeat (4) @(negedge clk); s = pc;
            repeat (16) @(negedge clk); ck(pc, s);
            ck({longWrite, insnReady}, 2'h2);
            @(posedge clk) setFlag <= j ? 4'h8 : 4'h1;
            @(posedge clk) setFlag <= 4'h0;
            k = 0;
            do begin @(negedge clk); k++; end while (longWrite !== 1'b0 && k < 12);
            ck(vectorTaken, !j);
            ck(clearFlag, j ? 3'h0 : 3'h1);
            if (!j) ck(pc, pc_bank_pkg::INT_VECTOR);
            repeat (3) @(negedge clk); ck(intFlag[3], j[0]);
            wipe <= 1'b1;
            @(posedge clk) wipe <= 1'b0;
        end
        $display("long write test done");
        final_report();
    end
endmodule
`default_nettype wire
